// [verilog/pstl_consts.svh]
// constants of the phase selective trip logic: offsets, fields, counts
`ifndef PSTL_CONSTS_SVH
`define PSTL_CONSTS_SVH

// ==========================================================
// register byte offsets
`define PSTL_REG_CTRL      12'h000
`define PSTL_REG_PULSE     12'h004
`define PSTL_REG_EVOLVE    12'h008
`define PSTL_REG_LIVE      12'h00C
`define PSTL_REG_IRQ_STAT  12'h010
`define PSTL_REG_IRQ_MASK  12'h014

// ==========================================================
// reset values and limits, milliseconds
`define PSTL_PULSE_RST     16'h0096
`define PSTL_EVOLVE_RST    16'h03E8
`define PSTL_TIME_MIN      16'h0032
`define PSTL_TIME_MAX      16'hEA60

// ==========================================================
// millisecond tick: time in ns over clock period in ns
`define PSTL_TICK_NS       1000000
`define PSTL_CLK_NS        40
`define PSTL_TICK_CYC      (`PSTL_TICK_NS / `PSTL_CLK_NS)

// ==========================================================
// status field positions: live and interrupt registers
`define PSTL_BIT_TRIP_A    0
`define PSTL_BIT_TRIP_B    1
`define PSTL_BIT_TRIP_C    2
`define PSTL_BIT_ANY       3
`define PSTL_BIT_ALL3      4

`endif

// [verilog/pstl_pkg.sv]
// types of the phase selective trip logic
package pstl_pkg;

	// ==========================================================
	// operating mode setting
	typedef enum logic [1:0] {
		PSTL_OFF   = 2'h0,
		PSTL_THREE = 2'h1,
		PSTL_MIXED = 2'h2
	} pstl_mode_e;

	// ==========================================================
	// trip request bundle from the protection functions
	typedef struct packed {
		logic singlePhaseRequest;
		logic allPhaseRequest;
		logic phaseARequest;
		logic phaseBRequest;
		logic phaseCRequest;
		logic forceAllPhases;
		logic block;
	} pstl_req_s;

	// ==========================================================
	// decided trip outputs
	typedef struct packed {
		logic allPhaseTrip;
		logic anyTripOut;
		logic phaseCTripOut;
		logic phaseBTripOut;
		logic phaseATripOut;
	} pstl_trip_s;

	// ==========================================================
	// all module state
	typedef struct packed {
		pstl_req_s  reqMeta;
		pstl_req_s  reqSync;
		pstl_mode_e mode;
		logic [15:0] pulseMs;
		logic [15:0] evolveMs;
		logic [4:0]  irqStat;
		logic [4:0]  irqMask;
		logic [15:0] tickCnt;
		logic        tick;
		logic [15:0] pulseCnt;
		logic [15:0] evolveCnt;
		logic        evolveOpen;
		pstl_trip_s  trip;
		logic        irq;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} pstl_state_s;

endpackage

// [verilog/phase_trip_decider.sv]
// phase selective trip decider with apb settings and trip events
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "pstl_consts.svh"

// Overview of operation
// - every asserted trip held at least the programmed minimum pulse, unless block or off mode ends it
// - two requested phases pull in the third, giving three-phase trip
// - force input turns a single-phase request into three-phase trip; a held pulse with no request keeps its phases
// - fault inside evolving window after a trip trips all three phases
// - mode off, three-phase only or mixed; off after reset
// - block input holds every trip output inactive
// - single-phase request trips the phases named by phase requests
// - three-phase request trips all three phases together
// - one trip output per phase shows the decided command
// - general trip high for any single or three-phase trip
// - three-phase output high only when all three phases trip
// - each edge of phase or general trip raises an event
// - live value of all five trip outputs is readable
module phase_trip_decider (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire pstl_pkg::pstl_req_s reqIn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic                  pready,
	output logic [31:0]           prdata,
	output logic                  pslverr,
	output pstl_pkg::pstl_trip_s  tripOut,
	output logic                  irq
);

	pstl_pkg::pstl_state_s s_q;
	pstl_pkg::pstl_state_s s_d;

	// ==========================================================
	// helpers
	// clamp a written time to the legal setting range
	function automatic logic [15:0] clampMs(input logic [31:0] v);
		if (v[15:0] < `PSTL_TIME_MIN || v[31:16] != 16'h0000) begin
			clampMs = (v[31:16] != 16'h0000) ? `PSTL_TIME_MAX
				: `PSTL_TIME_MIN;
		end else if (v[15:0] > `PSTL_TIME_MAX) begin
			clampMs = `PSTL_TIME_MAX;
		end else begin
			clampMs = v[15:0];
		end
	endfunction

	// trip vector packed into the five-bit status layout
	function automatic logic [4:0] tripBits(input pstl_pkg::pstl_trip_s t);
		tripBits = t;
	endfunction

	// one-hot register select shared by read and write paths;
	// zero means the offset is unmapped and the access is refused
	function automatic logic [5:0] regSel(input logic [11:0] a);
		regSel = 6'h00;
		if (a == `PSTL_REG_CTRL) begin
			regSel = 6'h01;
		end else if (a == `PSTL_REG_PULSE) begin
			regSel = 6'h02;
		end else if (a == `PSTL_REG_EVOLVE) begin
			regSel = 6'h04;
		end else if (a == `PSTL_REG_LIVE) begin
			regSel = 6'h08;
		end else if (a == `PSTL_REG_IRQ_STAT) begin
			regSel = 6'h10;
		end else if (a == `PSTL_REG_IRQ_MASK) begin
			regSel = 6'h20;
		end
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic       ra;
		logic       rb;
		logic       rc;
		logic       anyReq;
		logic       two;
		logic       go3;
		logic       hold;
		logic [2:0] ph;
		logic [4:0] evt;
		logic       wr;
		logic       acc;
		logic [5:0] sel;
		logic [31:0] rdat;
		pstl_pkg::pstl_trip_s nt;
		ra = 1'b0;
		rb = 1'b0;
		rc = 1'b0;
		anyReq = 1'b0;
		two = 1'b0;
		go3 = 1'b0;
		hold = 1'b0;
		ph = 3'h0;
		evt = 5'h00;
		nt = '0;
		wr = 1'b0;
		acc = 1'b0;
		sel = 6'h00;
		rdat = 32'h00000000;
		s_d = s_q;

		// pin inputs pass two flip-flops before use
		s_d.reqMeta = reqIn;
		s_d.reqSync = s_q.reqMeta;

		// millisecond tick divider
		s_d.tick = 1'b0;
		if (s_q.tickCnt == 16'(`PSTL_TICK_CYC - 1)) begin
			s_d.tickCnt = 16'h0000;
			s_d.tick = 1'b1;
		end else begin
			s_d.tickCnt = s_q.tickCnt + 16'h0001;
		end

		// request decoding; phase selects come from the requester
		ra = s_q.reqSync.singlePhaseRequest & s_q.reqSync.phaseARequest;
		rb = s_q.reqSync.singlePhaseRequest & s_q.reqSync.phaseBRequest;
		rc = s_q.reqSync.singlePhaseRequest & s_q.reqSync.phaseCRequest;
		anyReq = ra | rb | rc | s_q.reqSync.allPhaseRequest;
		two = (ra & rb) | (ra & rc) | (rb & rc);
		go3 = s_q.reqSync.allPhaseRequest
			| two
			| s_q.reqSync.forceAllPhases
			| (s_q.evolveOpen & ~s_q.trip.anyTripOut)
			| (s_q.mode == pstl_pkg::PSTL_THREE);
		ph = go3 ? 3'h7 : {rc, rb, ra};
		if (!anyReq) begin
			ph = 3'h0;
		end

		// pulse stretch: hold the latched phases until the minimum elapses
		hold = s_q.trip.anyTripOut && s_q.pulseCnt < s_q.pulseMs;
		nt.phaseATripOut = ph[0] | (hold & s_q.trip.phaseATripOut);
		nt.phaseBTripOut = ph[1] | (hold & s_q.trip.phaseBTripOut);
		nt.phaseCTripOut = ph[2] | (hold & s_q.trip.phaseCTripOut);
		// off mode or block kills every output; block wins over the pulse
		if (s_q.mode == pstl_pkg::PSTL_OFF
			|| s_q.reqSync.block) begin
			nt = '0;
		end
		nt.anyTripOut = nt.phaseATripOut | nt.phaseBTripOut
			| nt.phaseCTripOut;
		nt.allPhaseTrip = nt.phaseATripOut & nt.phaseBTripOut
			& nt.phaseCTripOut;
		s_d.trip = nt;

		// pulse counter held at zero while any request is present
		if (!nt.anyTripOut || anyReq) begin
			s_d.pulseCnt = 16'h0000;
		end else if (s_q.tick && s_q.pulseCnt != 16'hFFFF) begin
			s_d.pulseCnt = s_q.pulseCnt + 16'h0001;
		end

		// evolving window opens when a trip ends, closes after its time
		if (nt.anyTripOut) begin
			s_d.evolveOpen = 1'b0;
			s_d.evolveCnt = 16'h0000;
		end else if (s_q.trip.anyTripOut) begin
			s_d.evolveOpen = 1'b1;
			s_d.evolveCnt = 16'h0000;
		end else if (s_q.evolveOpen && s_q.tick) begin
			s_d.evolveCnt = s_q.evolveCnt + 16'h0001;
			if (s_q.evolveCnt + 16'h0001 >= s_q.evolveMs) begin
				s_d.evolveOpen = 1'b0;
			end
		end
		// events on any edge of phase or general trip
		evt = tripBits(nt) ^ tripBits(s_q.trip);
		evt[`PSTL_BIT_ALL3] = 1'b0;

		// apb slave: one wait state; the answer is registered at the
		// first access edge, but a write lands only at the edge that
		// completes the transfer, so no setting changes before the
		// master has seen ready
		sel = regSel(paddr);
		acc = psel & penable & ~s_q.pready;
		wr = psel & penable & pwrite & s_q.pready;
		if (sel[0]) begin
			rdat = {30'h0, s_q.mode};
		end else if (sel[1]) begin
			rdat = {16'h0000, s_q.pulseMs};
		end else if (sel[2]) begin
			rdat = {16'h0000, s_q.evolveMs};
		end else if (sel[3]) begin
			rdat = {27'h0, tripBits(s_q.trip)};
		end else if (sel[4]) begin
			rdat = {27'h0, s_q.irqStat};
		end else if (sel[5]) begin
			rdat = {27'h0, s_q.irqMask};
		end
		s_d.pready = acc;
		s_d.pslverr = acc & (sel == 6'h00);
		s_d.prdata = (acc & ~pwrite) ? rdat : 32'h00000000;
		// live status is read-only: a write to it is dropped quietly
		if (wr) begin
			if (sel[0]) begin
				s_d.mode = (pwdata[1:0] == 2'h3) ? pstl_pkg::PSTL_OFF
					: pstl_pkg::pstl_mode_e'(pwdata[1:0]);
			end else if (sel[1]) begin
				s_d.pulseMs = clampMs(pwdata);
			end else if (sel[2]) begin
				s_d.evolveMs = clampMs(pwdata);
			end else if (sel[4]) begin
				s_d.irqStat = s_q.irqStat & ~pwdata[4:0];
			end else if (sel[5]) begin
				s_d.irqMask = pwdata[4:0];
			end
		end
		// set wins over a simultaneous clear
		s_d.irqStat = s_d.irqStat | evt;
		s_d.irq = |(s_d.irqStat & s_d.irqMask);

		// synchronous reset
		if (srst) begin
			s_d = '0;
			s_d.mode = pstl_pkg::PSTL_OFF;
			s_d.pulseMs = `PSTL_PULSE_RST;
			s_d.evolveMs = `PSTL_EVOLVE_RST;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge core_clk) begin
		s_q <= s_d;
	end

	// outputs come straight from the state flip-flops
	assign tripOut = s_q.trip;
	assign irq     = s_q.irq;
	assign pready  = s_q.pready;
	assign prdata  = s_q.prdata;
	assign pslverr = s_q.pslverr;

endmodule

// [tb/pstl_requester.sv]
// requester model: protection logic driving the trip request pins
`timescale 1ns/100ps
module pstl_requester (
	input  wire logic                core_clk,
	input  wire pstl_pkg::pstl_req_s cmd,
	output pstl_pkg::pstl_req_s      reqOut
);
	// pins change just after an edge, as relay logic outputs would
	always_ff @(posedge core_clk) begin
		reqOut <= cmd;
	end
endmodule

// [tb/pstl_checker.sv]
// port assertions for the phase trip decider
`timescale 1ns/100ps
`include "pstl_consts.svh"
module pstl_checker (
	input wire logic                 core_clk,
	input wire logic                 srst,
	input wire pstl_pkg::pstl_req_s  reqIn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic                 pready,
	input wire logic [31:0]          prdata,
	input wire logic                 pslverr,
	input wire pstl_pkg::pstl_trip_s tripOut
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	// ==========================================================
	// bus answer
	sequence accessWait;
		psel && penable && !pready;
	endsequence
	apb_wait_a: assert property (accessWait |=> pready)
		else $error("no answer one cycle after access");
	apb_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	idle_data_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	live_read_a: assert property (psel && pready && !pwrite
		&& paddr == `PSTL_REG_LIVE |-> prdata[4:0] == $past(tripOut))
		else $error("live read differs from trip outputs");

	// ==========================================================
	// trip outputs; sync delay of three edges covered by five
	sequence blockHeld;
		reqIn.block [*5];
	endsequence
	block_clear_a: assert property (blockHeld |-> tripOut == 5'h00)
		else $error("trip while blocked");
	any_trip_a: assert property (tripOut.anyTripOut == (tripOut.phaseATripOut
		| tripOut.phaseBTripOut | tripOut.phaseCTripOut))
		else $error("general trip mismatch");
	all_phase_a: assert property (tripOut.allPhaseTrip == (tripOut.phaseATripOut
		& tripOut.phaseBTripOut & tripOut.phaseCTripOut))
		else $error("three-phase output mismatch");
	// pulses outlast any run here, so only a block may end one
	pulse_hold_a: assert property ($fell(tripOut.anyTripOut)
		|-> $past(reqIn.block, 3))
		else $error("trip ended before minimum pulse");
endmodule
bind phase_trip_decider pstl_checker i_pstl_checker (.core_clk, .srst,
	.reqIn, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
	.tripOut);

// [tb/phase_trip_decider_bench.sv]
// self-checking bench of the phase trip decider
`timescale 1ns/100ps
`include "pstl_consts.svh"
module phase_trip_decider_bench;
	logic                 core_clk = 1'b0;
	logic                 srst     = 1'b1;
	logic                 psel     = 1'b0;
	logic                 penable  = 1'b0;
	logic                 pwrite   = 1'b0;
	logic [11:0]          paddr    = 12'h000;
	logic [31:0]          pwdata   = 32'h0;
	logic                 pready;
	logic [31:0]          prdata;
	logic                 pslverr;
	logic                 irq;
	logic [31:0]          rd;
	logic                 er;
	pstl_pkg::pstl_req_s  cmd      = 7'h00;
	pstl_pkg::pstl_req_s  reqIn;
	pstl_pkg::pstl_trip_s tripOut;
	int                   miscompares = 0;
	int                   checks      = 0;
	// mode, request pins and hand-worked trip outputs
	logic [1:0] modeT [8] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h2, 2'h2};
	logic [6:0] reqT [8]  = '{7'h50, 7'h50, 7'h58, 7'h52, 7'h20, 7'h50,
		7'h44, 7'h51};
	logic [4:0] expT [8]  = '{5'h00, 5'h09, 5'h1F, 5'h1F, 5'h1F, 5'h1F,
		5'h0C, 5'h00};

	always #20 core_clk = ~core_clk;

	pstl_requester i_pstl_requester (.core_clk, .cmd, .reqOut(reqIn));
	phase_trip_decider i_phase_trip_decider (.core_clk, .srst, .reqIn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.tripOut, .irq);

	// ==========================================================
	// report, compare and bus tasks
	task end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// request held until ready is seen; bounded wait ends a hang
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			miscompares++;
			end_of_test();
		end
	endtask
	task rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	task restart(input logic [1:0] m);
		srst <= 1'b1;
		cmd <= 7'h00;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		apb(1'b1, `PSTL_REG_CTRL, {30'h0, m});
	endtask
	task send(input logic [6:0] r);
		cmd <= r;
		repeat (6) @(posedge core_clk);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		restart(2'h0);
		rdc("ctrl", `PSTL_REG_CTRL, 32'h0);
		rdc("pulse", `PSTL_REG_PULSE, 32'h96);
		rdc("evolve", `PSTL_REG_EVOLVE, 32'h3E8);
		rdc("mask", `PSTL_REG_IRQ_MASK, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk("slverr", 32'h1, 32'(er));
		apb(1'b1, 12'h020, 32'h0);
		chk("wr slverr", 32'h1, 32'(er));
		apb(1'b1, `PSTL_REG_CTRL, 32'h3);
		rdc("ctrl code 3", `PSTL_REG_CTRL, 32'h0);
		apb(1'b1, `PSTL_REG_PULSE, 32'h10);
		rdc("pulse min", `PSTL_REG_PULSE, 32'h32);
		apb(1'b1, `PSTL_REG_EVOLVE, 32'hFFFF);
		rdc("evolve max", `PSTL_REG_EVOLVE, 32'hEA60);
		apb(1'b1, `PSTL_REG_LIVE, 32'h1F);
		rdc("live ro", `PSTL_REG_LIVE, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			restart(modeT[i]);
			send(reqT[i]);
			chk("trip", 32'(expT[i]), 32'(tripOut));
			rdc("live", `PSTL_REG_LIVE, 32'(expT[i]));
		end
		$display("test decisions done");
		restart(2'h2);
		apb(1'b1, `PSTL_REG_IRQ_MASK, 32'h1F);
		send(7'h50);
		rdc("stat on", `PSTL_REG_IRQ_STAT, 32'h09);
		chk("irq on", 32'h1, 32'(irq));
		cmd <= 7'h00;
		repeat (500) @(posedge core_clk);
		chk("pulse hold", 32'h09, 32'(tripOut));
		apb(1'b1, `PSTL_REG_IRQ_STAT, 32'h09);
		rdc("stat clear", `PSTL_REG_IRQ_STAT, 32'h0);
		chk("irq off", 32'h0, 32'(irq));
		send(7'h01);
		chk("blocked", 32'h0, 32'(tripOut));
		rdc("stat off", `PSTL_REG_IRQ_STAT, 32'h09);
		send(7'h48);
		chk("evolving", 32'h1F, 32'(tripOut));
		rdc("stat all3", `PSTL_REG_IRQ_STAT, 32'h0F);
		$display("test events done");
		end_of_test();
	end
endmodule
